/* inc/gle_pkg.sv */
// package: register offsets, field positions, reset values and timing for the gauge/led slice
package gle_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] GLE_OFS_VOLT_HIGH   = 8'h22;
    localparam logic [7:0] GLE_OFS_VOLT_LOW    = 8'h23;
    localparam logic [7:0] GLE_OFS_EST_CFG     = 8'h24;
    localparam logic [7:0] GLE_OFS_CLEAR       = 8'h25;
    localparam logic [7:0] GLE_OFS_ENABLES     = 8'h26;
    localparam logic [7:0] GLE_OFS_BOOST_CFG   = 8'h27;
    localparam logic [7:0] GLE_OFS_SOC         = 8'h21;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int GLE_BIT_EST_ON       = 0;
    localparam int GLE_BIT_EST_SLEEP    = 1;
    localparam int GLE_BIT_EST_INTERVAL = 2;
    localparam int GLE_BIT_CLEAR        = 7;
    localparam int GLE_BIT_BOOST_ON     = 5;
    localparam int GLE_BIT_SINK_LO      = 1;
    localparam int GLE_BIT_SINK_HI      = 4;
    localparam int GLE_BIT_BACKLIGHT    = 0;
    localparam int GLE_BIT_STANDALONE   = 7;
    localparam int GLE_LOW_FIELD_LSB    = 3;
    localparam int GLE_VOLT_WIDTH       = 13;
    localparam int GLE_SOC_WIDTH        = 7;
    // ------------------------------------------------------------
    // reset values and masks
    // ------------------------------------------------------------
    localparam logic [7:0] GLE_RST_EST_CFG   = 8'h00;
    localparam logic [7:0] GLE_RST_ENABLES   = 8'h00;
    localparam logic [7:0] GLE_RST_BOOST_CFG = 8'h00;
    localparam logic [7:0] GLE_MASK_EST_CFG  = 8'h07;
    localparam logic [7:0] GLE_MASK_ENABLES  = 8'h3F;
    localparam logic [7:0] GLE_MASK_BOOST    = 8'hED;
    localparam logic [12:0] GLE_RST_VOLT     = 13'h0000;
    localparam logic [6:0]  GLE_RST_SOC      = 7'h00;
    // ------------------------------------------------------------
    // sleep refresh timing
    // ------------------------------------------------------------
    localparam longint GLE_CLK_HZ          = 10_000_000;
    localparam longint GLE_SLEEP_SHORT_MIN = 5;
    localparam longint GLE_SLEEP_LONG_MIN  = 20;
    localparam longint GLE_SLEEP_SHORT_CYC = GLE_SLEEP_SHORT_MIN * 60 * GLE_CLK_HZ;
    localparam longint GLE_SLEEP_LONG_CYC  = GLE_SLEEP_LONG_MIN * 60 * GLE_CLK_HZ;
endpackage

/* design/gle_interval_timer.sv */
// interval timer that paces estimator refreshes in sleep mode
`timescale 1ns/100ps
module gle_interval_timer #(
    parameter int           CNT_W     = 34,
    parameter logic [33:0]  SHORT_CYC = 34'h0_B2D0_5E00,
    parameter logic [33:0]  LONG_CYC  = 34'h2_CB41_7800
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic sys_rst,
    // control
    input  wire logic run,
    input  wire logic long_sel,
    // event
    output logic      tick
);
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] limit;

    // the limit compare is sized for the widest interval, so the width is fixed
    if (CNT_W != 34) begin : g_bad_width
        $error("gle_interval_timer: CNT_W must be 34");
    end

    assign limit = long_sel ? LONG_CYC : SHORT_CYC;

    // counter restarts when sleep leaves, so the first refresh comes one full interval later
    always_ff @(posedge clock) begin
        if (sys_rst || !run) begin
            count <= '0;
            tick  <= 1'b0;
        end else if (count >= limit - 34'h1) begin
            count <= '0;
            tick  <= 1'b1;
        end else begin
            count <= count + 34'h1;
            tick  <= 1'b0;
        end
    end
endmodule

/* design/gle_regs.sv */
// register slice: voltage readback, estimator config, result clear, boost and sink enables
`timescale 1ns/100ps

// Functional notes
// - the low voltage register shows result bits 4..0 in bits 7..3 and zero in bits 2..0.
// - in sleep mode the charge result refreshes every 5 minutes, or every 20 when bit 2 is set.
// - bit 1 of the estimator config selects sleep mode, reset 0.
// - bit 0 of the estimator config turns the estimator on, reset 0.
// - writing 1 to bit 7 of the clear register restores charge and both voltage results.
// - bit 5 of the enables drives the boost output only in standalone mode.
// - bits 4..1 of the enables switch sinks five..two unless that channel is grouped.
// - bit 0 of the enables switches the grouped backlight; all enables reset to 0.
// - the high voltage register shows result bits 12..5, read-only.
// - a separate bit selects boost mode: 0 led driving, 1 standalone.
module gle_regs
    import gle_pkg::*;
#(
    parameter logic [33:0] SHORT_CYC = 34'(GLE_SLEEP_SHORT_CYC),
    parameter logic [33:0] LONG_CYC  = 34'(GLE_SLEEP_LONG_CYC)
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // register port from the serial interface
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    // estimator measurement side
    input  wire logic        sample_valid,
    input  wire logic [12:0] sample_volt,
    input  wire logic [6:0]  sample_charge,
    // grouping of channels five..two into the backlight
    input  wire logic [3:0]  sink_grouped,
    // estimator controls
    output logic             estimator_on,
    output logic             estimator_sleep,
    output logic             estimator_refresh,
    // analog enables
    output logic             boost_output_on,
    output logic             sink_five_on,
    output logic             sink_four_on,
    output logic             sink_three_on,
    output logic             sink_two_on,
    output logic             grouped_backlight_on
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [7:0]  est_cfg;
    logic [7:0]  enables;
    logic [7:0]  boost_cfg;
    logic [12:0] volt_result;
    logic [6:0]  charge_percent_result;
    logic        clear_hit;
    logic        sleep_tick;
    logic        boost_standalone_select;
    logic [3:0]  next_sinks;
    logic        wr_est_cfg;
    logic        wr_enables;
    logic        wr_boost_cfg;
    logic        wr_clear;
    logic        sample_take;
    logic        sleep_run;
    logic [7:0]  next_rdata;

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // a zero interval would wrap the timer limit and stretch refreshes to one per 2^34 cycles
    if (SHORT_CYC == '0) begin : g_bad_short
        $error("gle_regs: SHORT_CYC must be nonzero");
    end
    if (LONG_CYC == '0) begin : g_bad_long
        $error("gle_regs: LONG_CYC must be nonzero");
    end
    if (LONG_CYC <= SHORT_CYC) begin : g_bad_order
        $error("gle_regs: LONG_CYC must exceed SHORT_CYC");
    end
    if (GLE_VOLT_WIDTH != 13 || GLE_SOC_WIDTH != 7) begin : g_bad_fields
        $error("gle_regs: result widths do not match the read fields");
    end

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    assign wr_est_cfg   = reg_wr && hit(reg_addr, GLE_OFS_EST_CFG);
    assign wr_enables   = reg_wr && hit(reg_addr, GLE_OFS_ENABLES);
    assign wr_boost_cfg = reg_wr && hit(reg_addr, GLE_OFS_BOOST_CFG);
    assign wr_clear     = reg_wr && hit(reg_addr, GLE_OFS_CLEAR);
    // the clear bit is never stored, so it acts once per write and always reads zero
    assign clear_hit = wr_clear && reg_wdata[GLE_BIT_CLEAR];
    assign boost_standalone_select = boost_cfg[GLE_BIT_STANDALONE];
    // samples are dropped while the estimator is off rather than queued for later
    assign sample_take = sample_valid && est_cfg[GLE_BIT_EST_ON];

    // ------------------------------------------------------------
    // writable registers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            est_cfg <= GLE_RST_EST_CFG;
        end else if (wr_est_cfg) begin
            est_cfg <= reg_wdata & GLE_MASK_EST_CFG;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            enables <= GLE_RST_ENABLES;
        end else if (wr_enables) begin
            enables <= reg_wdata & GLE_MASK_ENABLES;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            boost_cfg <= GLE_RST_BOOST_CFG;
        end else if (wr_boost_cfg) begin
            boost_cfg <= reg_wdata & GLE_MASK_BOOST;
        end
    end

    // ------------------------------------------------------------
    // sleep pacing
    // ------------------------------------------------------------
    // the timer only runs while the estimator is on and asleep
    assign sleep_run = est_cfg[GLE_BIT_EST_ON] && est_cfg[GLE_BIT_EST_SLEEP];
    gle_interval_timer #(
        .CNT_W     (34),
        .SHORT_CYC (SHORT_CYC),
        .LONG_CYC  (LONG_CYC)
    ) u_timer (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .run      (sleep_run),
        .long_sel (est_cfg[GLE_BIT_EST_INTERVAL]),
        .tick     (sleep_tick)
    );

    // ------------------------------------------------------------
    // results: clear beats a sample arriving in the same cycle
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst || clear_hit) begin
            volt_result           <= GLE_RST_VOLT;
            charge_percent_result <= GLE_RST_SOC;
        end else if (sample_take) begin
            volt_result           <= sample_volt;
            charge_percent_result <= sample_charge;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_comb begin
        case (reg_addr)
            GLE_OFS_SOC:       next_rdata = {1'b0, charge_percent_result};
            GLE_OFS_VOLT_HIGH: next_rdata = volt_result[12:5];
            GLE_OFS_VOLT_LOW:  next_rdata = {volt_result[4:0], 3'h0};
            GLE_OFS_EST_CFG:   next_rdata = est_cfg;
            GLE_OFS_CLEAR:     next_rdata = 8'h00;
            GLE_OFS_ENABLES:   next_rdata = enables;
            GLE_OFS_BOOST_CFG: next_rdata = boost_cfg;
            default:           next_rdata = 8'h00;
        endcase
    end

    // registered so the data stays put until the next read, whatever the address does
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // estimator and analog enables, all registered
    // ------------------------------------------------------------
    always_comb begin
        next_sinks = enables[GLE_BIT_SINK_HI:GLE_BIT_SINK_LO] & ~sink_grouped;
    end

    // refresh leaves as a one-cycle pulse; the estimator acts on each pulse once
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            estimator_on      <= 1'b0;
            estimator_sleep   <= 1'b0;
            estimator_refresh <= 1'b0;
        end else begin
            estimator_on      <= est_cfg[GLE_BIT_EST_ON];
            estimator_sleep   <= est_cfg[GLE_BIT_EST_SLEEP];
            estimator_refresh <= sleep_tick;
        end
    end

    // registered so the analog side never sees a glitch while a write decodes
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            boost_output_on      <= 1'b0;
            sink_five_on         <= 1'b0;
            sink_four_on         <= 1'b0;
            sink_three_on        <= 1'b0;
            sink_two_on          <= 1'b0;
            grouped_backlight_on <= 1'b0;
        end else begin
            boost_output_on      <= enables[GLE_BIT_BOOST_ON] && boost_standalone_select;
            sink_five_on         <= next_sinks[3];
            sink_four_on         <= next_sinks[2];
            sink_three_on        <= next_sinks[1];
            sink_two_on          <= next_sinks[0];
            grouped_backlight_on <= enables[GLE_BIT_BACKLIGHT];
        end
    end
endmodule

/* testbench/gle_regs_sva.sv */
// checker: port-level assertions for the register slice
`timescale 1ns/100ps
module gle_regs_sva (
    // clock, reset and register port
    input wire logic       clock,
    input wire logic       sys_rst,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // outputs and grouping
    input wire logic [3:0] sink_grouped,
    input wire logic       estimator_on,
    input wire logic       estimator_sleep,
    input wire logic       estimator_refresh,
    input wire logic       boost_output_on,
    input wire logic       sink_five_on,
    input wire logic       grouped_backlight_on
);
    logic stand;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    // shadow of the standalone bit, since the checker only sees ports
    always_ff @(posedge clock) begin
        if (sys_rst) stand <= 1'b0;
        else if (reg_wr && reg_addr == 8'h27) stand <= reg_wdata[7];
    end
    property p_cfg;
        logic [7:0] v;
        (reg_wr && reg_addr == 8'h24, v = reg_wdata) |->
            ##2 estimator_on == v[0] && estimator_sleep == v[1];
    endproperty
    property p_en;
        logic [7:0] v;
        (reg_wr && reg_addr == 8'h26, v = reg_wdata) |-> ##2 grouped_backlight_on == v[0]
            && sink_five_on == (v[4] && !sink_grouped[3]) && boost_output_on == (v[5] && stand);
    endproperty
    AST_RST_QUIET: assert property (disable iff (1'b0) sys_rst |=> !estimator_on
        && !boost_output_on && !grouped_backlight_on) else $error("outputs live in reset");
    AST_EST_CFG: assert property (p_cfg) else $error("estimator controls wrong");
    AST_ENABLES: assert property (p_en) else $error("enable outputs wrong");
    AST_LOW_PAD: assert property (reg_rd && reg_addr == 8'h23 |=> reg_rdata[2:0] == 3'h0)
        else $error("low voltage pad bits set");
    AST_CLR_READ: assert property (reg_rd && reg_addr == 8'h25 |=> reg_rdata == 8'h00)
        else $error("clear register reads nonzero");
    AST_CFG_PAD: assert property (reg_rd && reg_addr == 8'h24 |=> reg_rdata[7:3] == 5'h00)
        else $error("config unused bits set");
    AST_REFRESH_QUIET: assert property (!estimator_sleep [*4] |-> !estimator_refresh)
        else $error("refresh outside sleep");
    AST_REFRESH_GAP: assert property ($rose(estimator_refresh) |=> !estimator_refresh [*8])
        else $error("refresh pulses too close");
    COV_SLEEP: cover property ($rose(estimator_refresh));
    COV_BOOST: cover property ($rose(boost_output_on));
    COV_CLEAR: cover property (reg_wr && reg_addr == 8'h25 && reg_wdata[7]);
endmodule
bind gle_regs gle_regs_sva u_sva (.clock(clock), .sys_rst(sys_rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sink_grouped(sink_grouped), .estimator_on(estimator_on), .estimator_sleep(estimator_sleep),
    .estimator_refresh(estimator_refresh), .boost_output_on(boost_output_on),
    .sink_five_on(sink_five_on), .grouped_backlight_on(grouped_backlight_on));

/* testbench/gle_host.sv */
// host model: register writes and reads launched at the falling edge
`timescale 1ns/100ps
module gle_host (
    // clock and read data
    input  wire logic       clock,
    input  wire logic [7:0] reg_rdata,
    // register requests
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata
);
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end
    // released lines are inverted so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge clock);
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        reg_rd   = 1'b1;
        reg_addr = a;
        @(negedge clock);
        reg_rd   = 1'b0;
        reg_addr = ~a;
        @(negedge clock);
        d = reg_rdata;
    endtask
endmodule

/* testbench/tb_top.sv */
// self-checking bench for the register slice
`timescale 1ns/100ps
module tb_top;
    import gle_pkg::*;
    logic        clock, sys_rst, reg_wr, reg_rd, sample_valid, estimator_on, estimator_sleep;
    logic        estimator_refresh, boost_output_on, sink_five_on, sink_four_on, sink_three_on;
    logic        sink_two_on, grouped_backlight_on;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, en_v, bst_v;
    logic [12:0] sample_volt;
    logic [6:0]  sample_charge;
    logic [3:0]  sink_grouped;
    int          miscompares, n_tests, t0;
    // short sleep intervals so refresh timing fits in the run
    gle_regs #(.SHORT_CYC(34'd20), .LONG_CYC(34'd80)) i_dut (.clock(clock), .sys_rst(sys_rst),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .sample_valid(sample_valid), .sample_volt(sample_volt),
        .sample_charge(sample_charge), .sink_grouped(sink_grouped), .estimator_on(estimator_on),
        .estimator_sleep(estimator_sleep), .estimator_refresh(estimator_refresh),
        .boost_output_on(boost_output_on), .sink_five_on(sink_five_on),
        .sink_four_on(sink_four_on), .sink_three_on(sink_three_on), .sink_two_on(sink_two_on),
        .grouped_backlight_on(grouped_backlight_on));
    gle_host i_host (.clock(clock), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    function automatic logic [5:0] exp_pins(logic [7:0] e, logic [3:0] g, logic st);
        return {e[5] & st, e[4] & ~g[3], e[3] & ~g[2], e[2] & ~g[1], e[1] & ~g[0], e[0]};
    endfunction
    task automatic chk_reg(string n, logic [7:0] e, logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_pins(string n, logic [5:0] e, logic [5:0] g);
        chk_reg(n, {2'h0, e}, {2'h0, g});
    endtask
    task automatic rdc(logic [7:0] a, logic [7:0] e);
        logic [7:0] d;
        i_host.rd(a, d);
        chk_reg($sformatf("reg %h", a), e, d);
    endtask
    task automatic next_pulse(output int n);
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (estimator_refresh !== 1'b1 && n < 300);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    initial begin
        #(30000 * 100);
        miscompares++;
        wrap_up();
    end
    initial begin
        {sys_rst, sample_valid, sample_volt, sample_charge, sink_grouped} = {1'b1, 25'h0};
        miscompares = 0;
        n_tests = 0;
        t0 = $urandom(32664);
        repeat (6) @(negedge clock);
        sys_rst = 1'b0;
        for (int a = 8'h20; a <= 8'h28; a++) rdc(8'(a), 8'h00);
        $display("reset test done");
        // corners first: all enables in standalone, then all channels grouped
        for (int i = 0; i < 12; i++) begin
            @(negedge clock);
            sink_grouped = (i < 2) ? 4'(i * 15) : 4'($urandom);
            en_v = (i < 2) ? 8'hFF : 8'($urandom);
            bst_v = (i == 0) ? 8'h80 : 8'($urandom);
            i_host.wr(8'h27, bst_v);
            i_host.wr(8'h26, en_v);
            i_host.wr(8'h24, en_v);
            repeat (2) @(posedge clock);
            @(negedge clock);
            chk_pins("pins", exp_pins(en_v, sink_grouped, bst_v[7]), {boost_output_on,
                sink_five_on, sink_four_on, sink_three_on, sink_two_on, grouped_backlight_on});
            chk_pins("est", {4'h0, en_v[1:0]}, {4'h0, estimator_sleep, estimator_on});
            rdc(8'h26, en_v & 8'h3F);
            rdc(8'h24, en_v & 8'h07);
            rdc(8'h27, bst_v & 8'hED);
        end
        $display("enable test done");
        // a sample offered while the estimator is off must not reach the results
        i_host.wr(8'h24, 8'h00);
        {sample_valid, sample_volt} = {1'b1, 13'h1FFF};
        @(negedge clock);
        sample_valid = 1'b0;
        rdc(8'h22, 8'h00);
        i_host.wr(8'h24, 8'h01);
        for (int i = 0; i < 4; i++) begin
            sample_volt = (i == 0) ? 13'h1FFF : 13'($urandom);
            sample_charge = 7'($urandom);
            sample_valid = 1'b1;
            @(negedge clock);
            sample_valid = 1'b0;
            rdc(8'h22, sample_volt[12:5]);
            rdc(8'h23, {sample_volt[4:0], 3'h0});
            rdc(8'h21, {1'b0, sample_charge});
        end
        i_host.wr(8'h25, 8'h7F);
        rdc(8'h22, sample_volt[12:5]);
        i_host.wr(8'h25, 8'h80);
        for (int a = 8'h21; a <= 8'h23; a++) rdc(8'(a), 8'h00);
        $display("clear test done");
        i_host.wr(8'h24, 8'h03);
        next_pulse(t0);
        next_pulse(t0);
        chk_reg("short gap", 8'd20, 8'(t0));
        i_host.wr(8'h24, 8'h07);
        next_pulse(t0);
        next_pulse(t0);
        chk_reg("long gap", 8'd80, 8'(t0));
        $display("interval test done");
        wrap_up();
    end
endmodule
